//--- logic/can_tx_history_and_timestamp.v
`timescale 1ns/10ps
`default_nettype none
`include "can_tx_history_consts.vh"

module can_tx_history_and_timestamp (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Register bus, write side
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // Register bus, read side
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Operating mode and frame events
  input  wire        init_mode,
  input  wire        auto_block_transmit,
  input  wire        tx_done,
  input  wire [4:0]  tx_buffer,
  input  wire        sof_event,
  input  wire        eof_last_event,
  input  wire        rx_ok_buffer0,
  // Time stamp pin
  output reg         stamp_toggle_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  reg  [4:0]  transmit_history_list [0:`HIST_DEPTH-1];
  reg  [2:0]  last_out_index;
  reg  [2:0]  history_read_index;
  reg  [2:0]  unread_count;
  reg         history_overflow_flag;
  reg  [2:0]  stamp_ctrl;
  wire        lock_enable;
  wire        event_select;
  wire        output_enable;

  reg  [31:0] aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire        history_match_flag;
  wire        do_write;
  wire        ar_take;
  reg         wr_hist;
  reg         wr_stamp;
  reg         wr_known;
  reg         rd_hist;
  reg         rd_stamp;
  reg         rd_last;
  reg         rd_known;
  reg  [31:0] next_rdata;
  wire        append;
  wire [2:0]  hw_clear;
  wire [2:0]  next_stamp_ctrl;
  wire        toggle_now;
  wire [1:0]  wr_resp;
  wire [1:0]  rd_resp;
  wire        hist_read_pop;
  wire        ovf_clear;
  wire        record;
  wire        overwrite_mode;
  wire        sel_event;
  wire        lock_event;
  wire [2:0]  slot_next;
  wire [2:0]  slot_below;
  wire [2:0]  set_bits;
  wire [2:0]  clr_bits;

  assign history_match_flag = (unread_count == 3'h0);
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign wr_resp  = wr_known ? `RESP_OKAY : `RESP_SLVERR;
  assign rd_resp  = rd_known ? `RESP_OKAY : `RESP_SLVERR;

  // ==========================================================================
  // Write address decode
  // ==========================================================================
  always @* begin
    wr_hist  = 1'b0;
    wr_stamp = 1'b0;
    wr_known = 1'b0;
    if (aw_addr == `HIST_READ_ADDR) begin
      wr_hist  = 1'b1;
      wr_known = 1'b1;
    end else if (aw_addr == `STAMP_CTRL_ADDR) begin
      wr_stamp = 1'b1;
      wr_known = 1'b1;
    end else if (aw_addr == `LAST_OUT_ADDR) begin
      wr_known = 1'b1;
    end
  end

  // ==========================================================================
  // Read address decode
  // ==========================================================================
  always @* begin
    rd_hist  = 1'b0;
    rd_stamp = 1'b0;
    rd_last  = 1'b0;
    rd_known = 1'b0;
    if (s_axi_araddr == `HIST_READ_ADDR) begin
      rd_hist  = 1'b1;
      rd_known = 1'b1;
    end else if (s_axi_araddr == `STAMP_CTRL_ADDR) begin
      rd_stamp = 1'b1;
      rd_known = 1'b1;
    end else if (s_axi_araddr == `LAST_OUT_ADDR) begin
      rd_last  = 1'b1;
      rd_known = 1'b1;
    end
  end

  // ==========================================================================
  // History events
  // ==========================================================================
  // A history read consumes one unread entry
  assign hist_read_pop = ar_take && rd_hist && !history_match_flag;

  // Only lane 0 carries the clear bit
  assign ovf_clear = do_write && wr_hist && w_strb[0] &&
                     w_data[`HIST_OVF_BIT];

  // Low buffers are hidden while block transmit runs
  assign record = tx_done && !init_mode &&
                  !(auto_block_transmit &&
                    (tx_buffer <= `ABT_LAST_BUFFER));

  // Full list behaves as overflowed so the unread count stops at 7
  assign overwrite_mode = history_overflow_flag ||
                          (unread_count == `HIST_OVF_COUNT);
  assign slot_next  = last_out_index + 3'h1;
  assign slot_below = last_out_index - 3'h1;
  assign append     = record && !overwrite_mode;

  // ==========================================================================
  // Stamp events
  // ==========================================================================
  assign set_bits = (do_write && wr_stamp && w_strb[1]) ?
                    w_data[`STAMP_SET_LSB+2:`STAMP_SET_LSB] : 3'h0;
  assign clr_bits = (do_write && wr_stamp && w_strb[0]) ?
                    w_data[2:0] : 3'h0;

  assign sel_event  = event_select ? eof_last_event : sof_event;
  assign lock_event = lock_enable && rx_ok_buffer0;

  // ==========================================================================
  // Write channel
  // ==========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b0;
      aw_addr       <= 32'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr       <= s_axi_awaddr;
      aw_held       <= 1'b1;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held       <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // ==========================================================================
  // Write data channel
  // ==========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      w_held       <= 1'b1;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held       <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // ==========================================================================
  // Write response
  // ==========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  // Read data; unmapped addresses read as zero
  always @* begin
    next_rdata = 32'h0;
    if (rd_hist) begin
      next_rdata[`HIST_ENTRY_MSB:`HIST_ENTRY_LSB] =
        {3'h0, transmit_history_list[history_read_index]};
      next_rdata[`HIST_MATCH_BIT] = history_match_flag;
      next_rdata[`HIST_OVF_BIT]   = history_overflow_flag;
    end else if (rd_stamp) begin
      next_rdata[2:0] = {lock_enable, event_select,
                         output_enable};
    end else if (rd_last) begin
      next_rdata[7:0] =
        {3'h0, transmit_history_list[last_out_index]};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= rd_resp;
      s_axi_rdata   <= next_rdata;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Transmit history list
  // ==========================================================================
  genvar gi;
  generate
    // Overflow reuses the slot below last-out, else the next slot
    for (gi = 0; gi < `HIST_DEPTH; gi = gi + 1) begin : g_slot
      always @(posedge aclk) begin
        if (!aresetn || init_mode) begin
          transmit_history_list[gi] <= 5'h0;
        end else if (record) begin
          if (overwrite_mode && slot_below == gi) begin
            transmit_history_list[gi] <= tx_buffer;
          end else if (!overwrite_mode && slot_next == gi) begin
            transmit_history_list[gi] <= tx_buffer;
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // History pointers
  // ==========================================================================
  // Last-out reads a cleared slot until a transmit
  always @(posedge aclk) begin
    if (!aresetn || init_mode) begin
      last_out_index <= 3'h7;
    end else if (append) begin
      last_out_index <= slot_next;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || init_mode) begin
      history_read_index <= 3'h0;
    end else if (hist_read_pop) begin
      history_read_index <= history_read_index + 3'h1;
    end
  end

  // An append and a pop in one cycle leave the count as it is
  always @(posedge aclk) begin
    if (!aresetn || init_mode) begin
      unread_count <= 3'h0;
    end else if (append && !hist_read_pop) begin
      unread_count <= unread_count + 3'h1;
    end else if (hist_read_pop && !append) begin
      unread_count <= unread_count - 3'h1;
    end
  end

  // Setting wins over a simultaneous clear
  always @(posedge aclk) begin
    if (!aresetn || init_mode) begin
      history_overflow_flag <= 1'b0;
    end else if (record && (unread_count == `HIST_OVF_COUNT - 3'h1) &&
                 !hist_read_pop) begin
      history_overflow_flag <= 1'b1;
    end else if (record && overwrite_mode) begin
      history_overflow_flag <= 1'b1;
    end else if (ovf_clear) begin
      history_overflow_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Time stamp
  // ==========================================================================
  assign lock_enable   = stamp_ctrl[`STAMP_LOCK_BIT];
  assign event_select  = stamp_ctrl[`STAMP_SEL_BIT];
  assign output_enable = stamp_ctrl[`STAMP_EN_BIT];

  // Hardware lock beats a software set in the same cycle
  assign hw_clear = {2'b00, lock_event};

  // Set-only sets, clear-only clears, anything else holds
  genvar gb;
  generate
    for (gb = 0; gb < 3; gb = gb + 1) begin : g_ctrl
      assign next_stamp_ctrl[gb] =
        hw_clear[gb]                    ? 1'b0 :
        (set_bits[gb] && !clr_bits[gb]) ? 1'b1 :
        (!set_bits[gb] && clr_bits[gb]) ? 1'b0 :
                                          stamp_ctrl[gb];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      stamp_ctrl <= `STAMP_CTRL_RESET;
    end else begin
      stamp_ctrl <= next_stamp_ctrl;
    end
  end

  // ==========================================================================
  // Time stamp output
  // ==========================================================================
  assign toggle_now = output_enable && sel_event && !lock_event;

  always @(posedge aclk) begin
    if (!aresetn) begin
      stamp_toggle_out <= 1'b0;
    end else if (toggle_now) begin
      stamp_toggle_out <= ~stamp_toggle_out;
    end
  end

endmodule // can_tx_history_and_timestamp

`default_nettype wire

//--- logic/can_tx_history_consts.vh
// What this block does
// - Last-out register returns buffer number 0 to 31 last appended to the list; overwrites do not move it.
// - Last-out value is undefined until some buffer has transmitted a frame.
// - Last-out value is undefined if the match flag reads 1 after leaving init.
// - History read: entry in bits 15:8, match bit 1, overflow bit 0, rest zero.
// - History read returns the list entry picked by the read pointer.
// - Match flag is 0 while unread entries remain, 1 when none remain.
// - The entry field is not valid while the match flag is 1.
// - With overflow 0 and fewer than 7 unread entries, every transmit is recorded and unread entries are kept.
// - Overflow sets once 7 unread entries pile up; first 5 and the 7th are kept.
// - While overflow is set, new numbers overwrite the slot below last-out.
// - With auto block transmit, buffers 0 to 7 are not recorded.
// - Writing 1 to bit 0 of history register clears overflow; 0 does nothing.
// - Stamp control reads lock in bit 2, select bit 1, enable bit 0.
// - Set bits 10:8 and clear bits 2:0; set-only sets, clear-only clears.
// - With enable 1 the stamp output toggles on each selected event.
// - Event is start of frame when select is 0, last end-of-frame bit when 1.
// - With lock 0 the output toggles on every selected event.
// - With lock 1 the output freezes once buffer 0 receives a data frame.
// - The lock event clears the enable bit in hardware.
`ifndef CAN_TX_HISTORY_CONSTS_VH
`define CAN_TX_HISTORY_CONSTS_VH

// Printed register indices; byte address is four times the index
`define HIST_READ_INDEX      32'h03fec064
`define STAMP_CTRL_INDEX     32'h03fec066
`define LAST_OUT_INDEX       32'h03fec068
`define HIST_READ_ADDR       32'h0ffb0190
`define STAMP_CTRL_ADDR      32'h0ffb0198
`define LAST_OUT_ADDR        32'h0ffb01a0

`define HIST_DEPTH           8
`define HIST_OVF_COUNT       3'h7
`define ABT_LAST_BUFFER      5'h07

`define HIST_ENTRY_MSB       15
`define HIST_ENTRY_LSB       8
`define HIST_MATCH_BIT       1
`define HIST_OVF_BIT         0
`define STAMP_LOCK_BIT       2
`define STAMP_SEL_BIT        1
`define STAMP_EN_BIT         0
`define STAMP_SET_LSB        8

`define STAMP_CTRL_RESET     3'h0
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

//--- tb/can_tx_history_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Bus and stamp checks
module can_tx_history_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sof_event,
  input wire logic        eof_last_event,
  input wire logic        stamp_toggle_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer not one cycle after take");
  a_bvalid_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_rvalid_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_ready_drop: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during answer");
  a_arready_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready during answer");
  a_toggle_cause: assert property (
    $changed(stamp_toggle_out) |-> $past(sof_event) || $past(eof_last_event))
    else $error("stamp output moved without an event");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
endmodule // can_tx_history_assertions

bind can_tx_history_and_timestamp can_tx_history_assertions chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .sof_event, .eof_last_event, .stamp_toggle_out);
`default_nettype wire

//--- tb/can_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Protocol engine pulses
module can_engine_model (
  input  wire logic       aclk,
  output var  logic       tx_done,
  output var  logic [4:0] tx_buffer,
  output var  logic       sof_event,
  output var  logic       eof_last_event,
  output var  logic       rx_ok_buffer0
);
  initial begin
    tx_done = 1'b0;
    tx_buffer = 5'h00;
    {rx_ok_buffer0, eof_last_event, sof_event} = 3'h0;
  end
  task automatic send_tx(input logic [4:0] n);
    tx_done <= 1'b1;
    tx_buffer <= n;
    @(posedge aclk);
    tx_done <= 1'b0;
    tx_buffer <= ~n;
    @(posedge aclk);
  endtask
  // Bits are receive-ok, end of frame, start of frame
  task automatic frame(input logic [2:0] k);
    {rx_ok_buffer0, eof_last_event, sof_event} <= k;
    @(posedge aclk);
    {rx_ok_buffer0, eof_last_event, sof_event} <= 3'h0;
  endtask
endmodule // can_engine_model
`default_nettype wire

//--- tb/can_tx_history_and_timestamp_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "can_tx_history_consts.vh"
// ====================
// Bench
module can_tx_history_and_timestamp_tb;
  logic        aclk, aresetn, init_mode, auto_block_transmit, exp_out;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, stamp_toggle_out, tx_done;
  logic        sof_event, eof_last_event, rx_ok_buffer0;
  logic [4:0]  tx_buffer;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
  int          mismatches, compares;
  localparam logic [15:0] ctl_wr [5] = '{16'h0700, 16'h0005, 16'h0202,
                                        16'h0000, 16'h0002};
  localparam logic [2:0]  ctl_rd [5] = '{3'h7, 3'h2, 3'h2, 3'h2, 3'h0};

  can_tx_history_and_timestamp DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .init_mode,
    .auto_block_transmit, .tx_done, .tx_buffer, .sof_event,
    .eof_last_event, .rx_ok_buffer0, .stamp_toggle_out);
  can_engine_model eng (.aclk, .tx_done, .tx_buffer, .sof_event,
    .eof_last_event, .rx_ok_buffer0);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hf);
    s_axi_awaddr <= a;
    s_axi_wstrb <= s;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  // Entry field ignored while the match flag is expected high
  task automatic hist(input logic [7:0] n, input logic [1:0] f);
    rd(`HIST_READ_ADDR);
    chk("history", {16'h0, n, 6'h0, f},
        f[1] ? {rdv[31:16], n, rdv[7:0]} : rdv);
  endtask

  task automatic tog(input logic [2:0] k, input logic t);
    eng.frame(k);
    exp_out = exp_out ^ t;
    #1;
    chk("stamp_out", {31'h0, exp_out}, {31'h0, stamp_toggle_out});
    @(posedge aclk);
  endtask

  task automatic clear_list();
    init_mode <= 1'b1;
    @(posedge aclk);
    init_mode <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic t_reset();
    hist(8'h00, 2'b10);
    rd(`STAMP_CTRL_ADDR);
    chk("control", 32'h0, rdv);
    rd(`LAST_OUT_ADDR + 32'h4);
    chk("rresp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    wr(`LAST_OUT_ADDR + 32'h4, 32'h1);
    chk("bresp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
  endtask

  task automatic t_list();
    eng.send_tx(5'd5);
    eng.send_tx(5'd12);
    eng.send_tx(5'd31);
    rd(`LAST_OUT_ADDR);
    chk("last_out", 32'd31, rdv);
    hist(8'd5, 2'b00);
    hist(8'd12, 2'b00);
    hist(8'd31, 2'b00);
    hist(8'd0, 2'b10);
  endtask

  task automatic t_overflow();
    eng.send_tx(5'd20);
    clear_list();
    hist(8'd0, 2'b10);
    for (int i = 1; i <= 9; i++)
      eng.send_tx(i[4:0]);
    rd(`LAST_OUT_ADDR);
    chk("last_out", 32'd7, rdv);
    hist(8'd1, 2'b01);
    hist(8'd2, 2'b01);
    wr(`HIST_READ_ADDR, 32'h0);
    wr(`HIST_READ_ADDR, 32'h1, 4'he);
    hist(8'd3, 2'b01);
    wr(`HIST_READ_ADDR, 32'h1);
    hist(8'd4, 2'b00);
    hist(8'd5, 2'b00);
  endtask

  task automatic t_abt();
    clear_list();
    auto_block_transmit <= 1'b1;
    eng.send_tx(5'd7);
    eng.send_tx(5'd8);
    hist(8'd8, 2'b00);
    hist(8'd0, 2'b10);
    auto_block_transmit <= 1'b0;
  endtask

  task automatic t_stamp();
    wr(`STAMP_CTRL_ADDR, 32'h0700, 4'h1);
    rd(`STAMP_CTRL_ADDR);
    chk("control", 32'h0, rdv);
    for (int i = 0; i < 5; i++) begin
      wr(`STAMP_CTRL_ADDR, {16'h0, ctl_wr[i]});
      rd(`STAMP_CTRL_ADDR);
      chk("control", {29'h0, ctl_rd[i]}, rdv);
    end
    wr(`STAMP_CTRL_ADDR, 32'h0100);
    tog(3'b001, 1'b1);
    tog(3'b010, 1'b0);
    wr(`STAMP_CTRL_ADDR, 32'h0200);
    tog(3'b010, 1'b1);
    tog(3'b001, 1'b0);
    wr(`STAMP_CTRL_ADDR, 32'h0001);
    tog(3'b011, 1'b0);
  endtask

  // Block transmit stays off while the lock is used
  task automatic t_lock();
    wr(`STAMP_CTRL_ADDR, 32'h0502);
    tog(3'b001, 1'b1);
    tog(3'b100, 1'b0);
    rd(`STAMP_CTRL_ADDR);
    chk("control", 32'h4, rdv);
    tog(3'b001, 1'b0);
  endtask

  initial begin
    #400us;
    mismatches++;
    finish_test();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'hf;
    {init_mode, auto_block_transmit, exp_out} = 3'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_list();
    t_overflow();
    t_abt();
    t_stamp();
    t_lock();
    finish_test();
  end
endmodule // can_tx_history_and_timestamp_tb
`default_nettype wire
